/* src/sst_regs.vh */
// Register map, fields, reset values and timing constants of the transceiver
`ifndef SST_REGS_VH
`define SST_REGS_VH

// ------------------------
// Register indices and byte addresses (four times the index)
// ------------------------
`define SST_IDX_MODE        8'hb4
`define SST_IDX_RELOAD      8'hb5
`define SST_IDX_DATA        8'hb6
`define SST_IDX_STATUS      8'hb7
`define SST_IDX_PORT        8'hb8
`define SST_IDX_PINS        8'hb9
`define SST_ADDR_W          12
`define SST_ADDR_MODE       ({2'b00, `SST_IDX_MODE, 2'b00})
`define SST_ADDR_RELOAD     ({2'b00, `SST_IDX_RELOAD, 2'b00})
`define SST_ADDR_DATA       ({2'b00, `SST_IDX_DATA, 2'b00})
`define SST_ADDR_STATUS     ({2'b00, `SST_IDX_STATUS, 2'b00})
`define SST_ADDR_PORT       ({2'b00, `SST_IDX_PORT, 2'b00})

// ------------------------
// Mode register fields
// ------------------------
`define SST_MODE_ENABLE     7
`define SST_MODE_START      6
`define SST_MODE_RATE_HI    5
`define SST_MODE_RATE_LO    4
`define SST_MODE_LSB_FIRST  3
`define SST_MODE_SLAVE      2
`define SST_MODE_CLOCK_IDLE_POLARITY_BIT       1
`define SST_MODE_SAMPLE_PHASE_BIT       0

// Rate select codes
`define SST_RATE_CPU        2'b00
`define SST_RATE_DIV32      2'b01
`define SST_RATE_DIV16      2'b10
`define SST_RATE_DIV8       2'b11

// Prescaler terminal counts for the divided rates and the post-scaler end count
`define SST_PRE_END32       5'h1f
`define SST_PRE_END16       5'h0f
`define SST_PRE_END8        5'h07
`define SST_POST_END        8'hff

// ------------------------
// Status and port control fields
// ------------------------
`define SST_STAT_DONE       0
`define SST_STAT_OVERRUN    1
`define SST_STAT_BUSY       2
`define SST_PORT_DIR_LO     0
`define SST_PORT_DIR_HI     2
`define SST_PORT_OPEN_DRAIN 3
`define SST_PORT_OUT_LO     4
`define SST_PORT_OUT_HI     6

// ------------------------
// Reset values, bus answers and the index of the last bit of a byte
// ------------------------
`define SST_RST_MODE        8'h00
`define SST_RST_RELOAD      8'h00
`define SST_RST_DATA        8'h00
`define SST_RST_PORT        8'h00
`define SST_RESP_OKAY       2'b00
`define SST_RESP_SLVERR     2'b10
`define SST_BITS_LAST       3'h7

`endif

/* src/sst_clkgen.v */
// Rate prescaler and auto-reload post-scaler that paces the master serial clock
`timescale 1ns/1ps
`default_nettype none
`include "sst_regs.vh"

module sst_clkgen (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       run,
    input  wire [1:0] rate,
    input  wire [7:0] reload,
    output wire       tick
);

    reg  [4:0] pre;
    reg  [7:0] post;
    reg        src;

    // ------------------------
    // Source pulse from the selected rate
    // ------------------------
    always @* begin
        case (rate)
            `SST_RATE_CPU:   src = 1'b1;
            `SST_RATE_DIV32: src = (pre == `SST_PRE_END32);
            `SST_RATE_DIV16: src = ({1'b0, pre[3:0]} == `SST_PRE_END16);
            `SST_RATE_DIV8:  src = ({2'b00, pre[2:0]} == `SST_PRE_END8);
            default:         src = 1'b0;
        endcase
    end

    // Post-scaler expires at its end count and reloads [R19]
    assign tick = src & (post == `SST_POST_END);

    // ------------------------
    // Counters; held at their start point while idle so every frame
    // begins with a full first half period
    // ------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            pre  <= 5'h00;
            post <= `SST_RST_RELOAD;
        end else if (!run) begin
            pre  <= 5'h00;
            post <= reload;
        end else begin
            pre <= pre + 5'h01;
            if (src) begin
                if (tick)
                    post <= reload;          // Auto reload [R19]
                else
                    post <= post + 8'h01;
            end
        end
    end

endmodule
`default_nettype wire

/* src/sst_top.v */
// Synchronous serial transceiver with AXI4-Lite registers and shared pins
`timescale 1ns/1ps
`default_nettype none
`include "sst_regs.vh"

// Contract
// R1: Enable plus start shifts one byte unaided
// R2: Three-bit counter; flag after eight bits
// R3: Start clears itself when byte is done
// R4: Firmware waits before rewriting transmit byte
// R5: Received byte copied out; read before next
// R6: Enable bit hands pins to transceiver
// R7: Start bit reads one while busy
// R8: Rate field picks master clock source
// R9: Order bit picks MSB or LSB first
// R10: Clock source bit picks master or slave
// R11: Polarity bit sets serial clock idle level
// R12: Phase bit picks first or second edge sampling
// R13: Firmware enables first, starts later
// R14: Clock pin direction forced by role
// R15: Data output pin forced to output
// R16: Firmware sets data input pin as input
// R17: Disabled pins follow port direction only
// R18: One data buffer; reads give received byte
// R19: Clock counter reloads at end count
// R20: Firmware keeps reload within allowed range
// R21: Both ends share one edge configuration
// R22: Data output pin may be open drain
// R23: Serial clock toggles at each expiry
// R24: Done flag sets as start clears, sticky
module sst_top (
    input  wire                   aclk,
    input  wire                   aresetn,
    input  wire [`SST_ADDR_W-1:0] s_axi_awaddr,
    input  wire                   s_axi_awvalid,
    output wire                   s_axi_awready,
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    input  wire                   s_axi_wvalid,
    output wire                   s_axi_wready,
    output reg  [1:0]             s_axi_bresp,
    output reg                    s_axi_bvalid,
    input  wire                   s_axi_bready,
    input  wire [`SST_ADDR_W-1:0] s_axi_araddr,
    input  wire                   s_axi_arvalid,
    output wire                   s_axi_arready,
    output reg  [31:0]            s_axi_rdata,
    output reg  [1:0]             s_axi_rresp,
    output reg                    s_axi_rvalid,
    input  wire                   s_axi_rready,
    input  wire                   sck_i,
    output reg                    sck_o,
    output reg                    sck_oe_n,
    input  wire                   sdi_i,
    output reg                    sdi_o,
    output reg                    sdi_oe_n,
    input  wire                   sdo_i,
    output reg                    sdo_o,
    output reg                    sdo_oe_n,
    output wire                   done_flag
);

    // ------------------------
    // Registers and state
    // ------------------------
    reg  [7:0]             mode;
    reg  [7:0]             reload;
    reg  [7:0]             data_buf;
    reg  [7:0]             port_ctrl;
    reg                    done;
    reg                    overrun;
    reg                    rx_unread;
    reg  [7:0]             tx_sh;
    reg  [7:0]             rx_sh;
    reg  [2:0]             bit_cnt;
    reg                    half;
    reg                    msck;
    reg  [2:0]             pin_s1;
    reg  [2:0]             pin_s2;
    reg  [2:0]             pin_s3;
    reg  [`SST_ADDR_W-1:0] aw_addr;
    reg  [7:0]             w_data;
    reg                    w_lane0;
    reg                    aw_have;
    reg                    w_have;

    wire       enable    = mode[`SST_MODE_ENABLE];
    wire       busy      = mode[`SST_MODE_START];
    wire       slave     = mode[`SST_MODE_SLAVE];
    wire       lsb_first = mode[`SST_MODE_LSB_FIRST];
    wire       clock_idle_polarity_bit      = mode[`SST_MODE_CLOCK_IDLE_POLARITY_BIT];
    wire       sample_phase_bit      = mode[`SST_MODE_SAMPLE_PHASE_BIT];
    wire       running   = enable & busy;
    wire [2:0] pin_in    = {sdo_i, sdi_i, sck_i};
    wire       tick;

    // ------------------------
    // Pin synchronisers: two flops per pin, third stage for edge finding
    // ------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always @(posedge aclk) begin
                if (!aresetn) begin
                    pin_s1[gi] <= 1'b0;
                    pin_s2[gi] <= 1'b0;
                    pin_s3[gi] <= 1'b0;
                end else begin
                    pin_s1[gi] <= pin_in[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                end
            end
        end
    endgenerate

    // ------------------------
    // Clock generation; rate only matters in master mode
    // ------------------------
    sst_clkgen u_clkgen (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (running & ~slave),                           // [R8]
        .rate    (mode[`SST_MODE_RATE_HI:`SST_MODE_RATE_LO]),  // [R8]
        .reload  (reload),
        .tick    (tick)
    );

    // Shift edge: internal expiry in master, sensed pin edge in slave [R10]
    wire edge_ev   = running & (slave ? (pin_s2[0] ^ pin_s3[0]) : tick);
    wire leading   = ~half;
    wire sample_ev = edge_ev & (leading ^ sample_phase_bit);               // [R12] [R21]
    wire shift_ev  = edge_ev & ~(leading ^ sample_phase_bit) & (~leading | (bit_cnt != 3'h0));
    wire last_ev   = edge_ev & ~leading & (bit_cnt == `SST_BITS_LAST);
    wire tx_bit    = lsb_first ? tx_sh[0] : tx_sh[7];          // [R9]

    // Incoming bit joins from the far end of the shifter [R9]
    wire       sample_sel = sample_ev;
    wire [7:0] rx_next = ~sample_sel ? rx_sh :
                         (lsb_first ? {pin_s2[1], rx_sh[7:1]} : {rx_sh[6:0], pin_s2[1]});

    // ------------------------
    // AXI4-Lite handshakes: address and data taken in either order
    // ------------------------
    assign s_axi_awready = ~aw_have & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_have & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire       do_write = aw_have & w_have;
    wire       rd_take  = s_axi_arvalid & s_axi_arready;
    wire [9:0] wr_idx   = aw_addr[`SST_ADDR_W-1:2];
    wire [9:0] rd_idx   = s_axi_araddr[`SST_ADDR_W-1:2];
    wire       wr_hit   = (wr_idx[9:8] == 2'b00) &&
                          (wr_idx[7:0] >= `SST_IDX_MODE) && (wr_idx[7:0] <= `SST_IDX_PINS);
    wire       wr_mode  = do_write & w_lane0 & (wr_idx == {2'b00, `SST_IDX_MODE});
    wire       wr_rld   = do_write & w_lane0 & (wr_idx == {2'b00, `SST_IDX_RELOAD});
    wire       wr_data  = do_write & w_lane0 & (wr_idx == {2'b00, `SST_IDX_DATA});
    wire       wr_stat  = do_write & w_lane0 & (wr_idx == {2'b00, `SST_IDX_STATUS});
    wire       wr_port  = do_write & w_lane0 & (wr_idx == {2'b00, `SST_IDX_PORT});
    wire       rd_data  = rd_take & (rd_idx == {2'b00, `SST_IDX_DATA});

    // Start is only honoured once enable already stood before this write
    wire       new_start = w_data[`SST_MODE_START] & enable;    // [R13]
    wire       launch    = wr_mode & new_start & ~busy;

    // Holding registers and write response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr      <= {`SST_ADDR_W{1'b0}};
            w_data       <= 8'h00;
            w_lane0      <= 1'b0;
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SST_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_have <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
                w_have  <= 1'b1;
            end
            if (do_write) begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `SST_RESP_OKAY : `SST_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------
    // Read path: one cycle from address to data, narrow data in low bits
    // ------------------------
    reg [7:0] rd_mux;
    reg       rd_ok;
    always @* begin
        rd_ok  = 1'b1;
        rd_mux = 8'h00;
        case (rd_idx)
            {2'b00, `SST_IDX_MODE}:   rd_mux = mode;                        // [R7]
            {2'b00, `SST_IDX_RELOAD}: rd_mux = 8'h00;                       // Write only
            {2'b00, `SST_IDX_DATA}:   rd_mux = data_buf;                    // [R18]
            {2'b00, `SST_IDX_STATUS}: rd_mux = {5'h00, busy, overrun, done};
            {2'b00, `SST_IDX_PORT}:   rd_mux = port_ctrl;
            {2'b00, `SST_IDX_PINS}:   rd_mux = {5'h00, pin_s2};
            default:                  rd_ok  = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `SST_RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_mux};
            s_axi_rresp  <= rd_ok ? `SST_RESP_OKAY : `SST_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------
    // Registers and shift engine share one process so that
    // hardware updates and bus writes have one ordered driver
    // ------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            mode      <= `SST_RST_MODE;
            reload    <= `SST_RST_RELOAD;
            data_buf  <= `SST_RST_DATA;
            port_ctrl <= `SST_RST_PORT;
            done      <= 1'b0;
            overrun   <= 1'b0;
            rx_unread <= 1'b0;
            tx_sh     <= 8'h00;
            rx_sh     <= 8'h00;
            bit_cnt   <= 3'h0;
            half      <= 1'b0;
            msck      <= 1'b0;
        end else begin
            // Plain register writes
            if (wr_rld)
                reload <= w_data;
            if (wr_port)
                port_ctrl <= w_data;
            if (wr_data)
                data_buf <= w_data;                            // [R18]

            // Flag clears first so a same-cycle event below still sets them
            if (wr_stat && w_data[`SST_STAT_DONE])
                done <= 1'b0;
            if (wr_stat && w_data[`SST_STAT_OVERRUN])
                overrun <= 1'b0;
            if (rd_data)
                rx_unread <= 1'b0;                             // [R5]

            // Master clock rests at its idle level outside a frame
            if (!running || slave)
                msck <= clock_idle_polarity_bit;                                  // [R11]
            else if (tick)
                msck <= ~msck;                                 // [R23]

            // Bit progress
            if (edge_ev) begin
                half <= ~half;
                if (!leading)
                    bit_cnt <= bit_cnt + 3'h1;                 // [R2]
            end
            if (shift_ev)
                tx_sh <= lsb_first ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
            rx_sh <= rx_next;

            // Mode write; start may only be raised, or dropped to abort
            if (wr_mode)
                mode <= {w_data[7], new_start, w_data[5:0]};

            // Launch: snapshot the buffer, the engine then runs unaided [R1]
            if (launch) begin
                tx_sh   <= data_buf;
                rx_sh   <= 8'h00;
                bit_cnt <= 3'h0;
                half    <= 1'b0;
            end

            // End of byte: start self-clears, flag set in the same cycle
            if (last_ev) begin
                mode[`SST_MODE_START] <= 1'b0;                 // [R3] [R7]
                done                  <= 1'b1;                 // [R24] [R2]
                data_buf              <= rx_next;              // [R5] [R18]
                rx_unread             <= 1'b1;
                if (rx_unread && !rd_data)
                    overrun <= 1'b1;                           // [R5]
            end

            // Disabling the function also stops any transfer
            if (wr_mode && !w_data[`SST_MODE_ENABLE])
                mode[`SST_MODE_START] <= 1'b0;
        end
    end

    assign done_flag = done;                                   // [R24]

    // ------------------------
    // Pin ownership and direction, registered so the pins never glitch
    // ------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            sck_o    <= 1'b0;
            sck_oe_n <= 1'b1;
            sdi_o    <= 1'b0;
            sdi_oe_n <= 1'b1;
            sdo_o    <= 1'b0;
            sdo_oe_n <= 1'b1;
        end else begin
            // Data input is never forced; firmware owns its direction
            sdi_o    <= port_ctrl[`SST_PORT_OUT_LO + 1];
            sdi_oe_n <= ~port_ctrl[`SST_PORT_DIR_LO + 1];
            if (enable) begin
                // Clock pin follows role, data out drives unless open drain [R6] [R14] [R15]
                sck_o    <= slave ? 1'b0 : msck;
                sck_oe_n <= slave;                             // [R14]
                if (port_ctrl[`SST_PORT_OPEN_DRAIN]) begin
                    sdo_o    <= 1'b0;
                    sdo_oe_n <= tx_bit;                        // [R22]
                end else begin
                    sdo_o    <= tx_bit;
                    sdo_oe_n <= 1'b0;                          // [R15]
                end
            end else begin
                // Plain port: direction register alone decides [R17]
                sck_o    <= port_ctrl[`SST_PORT_OUT_LO];
                sck_oe_n <= ~port_ctrl[`SST_PORT_DIR_LO];
                sdo_o    <= port_ctrl[`SST_PORT_OUT_HI];
                sdo_oe_n <= ~port_ctrl[`SST_PORT_DIR_HI];
            end
        end
    end

endmodule
`default_nettype wire

/* testbench/sst_properties.sv */
// Concurrent checks on the transceiver's bus and pin ports
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Port checker
// --------------------------------
module sst_properties (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        sck_o,
    input wire logic        sck_oe_n,
    input wire logic        done_flag
);
    // One clock domain
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    ar_block_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read taken while busy");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    rdata_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    // Flag drops only two edges after a firmware write
    done_sticky_a: assert property ($fell(done_flag) |-> $past(s_axi_wvalid, 2))
        else $error("done flag cleared on its own");
    // The pin lags one cycle; the quiet window starts three edges after the rise
    sck_quiet_a: assert property ($rose(done_flag) && !sck_oe_n
        |=> ##2 $stable(sck_o) [*4]) else $error("serial clock moved after byte end");
endmodule
`default_nettype wire

/* testbench/sst_peer.sv */
// Behavioural far-side device on the three-wire link
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Link peer
// --------------------------------
module sst_peer (
    input  wire logic       arm,
    input  wire logic       clock_idle_polarity_bit,
    input  wire logic       sample_phase_bit,
    input  wire logic       lsb_first,
    input  wire logic [7:0] tx,
    input  wire logic       sck_in,
    input  wire logic       sd_in,
    output wire logic       sck_out,
    output wire logic       sd_out,
    output logic      [7:0] rx
);
    logic tog = 1'b0;
    int   lead = 0;
    int   trail = 0;
    int   idx;
    // Clock rests at its idle level outside frames
    assign sck_out = clock_idle_polarity_bit ^ tog;
    // Bit moves on trailing edges (phase 0) or leading edges but the first (phase 1)
    assign idx = sample_phase_bit ? ((lead > 0) ? lead - 1 : 0) : trail;
    // After the byte the line shows the inverse of the last bit in phase 0; in phase 1 it holds the last bit
    assign sd_out = (idx < 8) ? tx[lsb_first ? idx : 7 - idx] : ~tx[lsb_first ? 7 : 0];
    // Count edges and sample on the phase the mode asks for
    always @(sck_in or negedge arm) begin
        if (!arm) begin
            lead = 0;
            trail = 0;
        end else begin
            if (sck_in != clock_idle_polarity_bit) lead++;
            else trail++;
            if ((sck_in != clock_idle_polarity_bit) != sample_phase_bit) begin
                rx = lsb_first ? {sd_in, rx[7:1]} : {rx[6:0], sd_in};
            end
        end
    end
    // Eight periods of 64 ns, offset from the block's clock grid
    task automatic burst();
        #3;
        repeat (16) begin
            #32 tog = ~tog;
        end
    endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
`include "sst_regs.vh"
// --------------------------------
// Bench
// --------------------------------
module tb_top;
    logic                   aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic                   arvalid = 0, rready = 0, p_arm = 0, p_clock_idle_polarity_bit = 0, p_sample_phase_bit = 0;
    logic                   p_lsb = 0, prev_sck = 0;
    logic [`SST_ADDR_W-1:0] awaddr = 0, araddr = 0;
    logic [31:0]            wdata = 0, rv, last_gap = 0, run_len = 0;
    logic [7:0]             p_tx = 0, p_rx, cfg, tx, rel, port;
    logic [1:0]             resp;
    wire                    awready, wready, bvalid, arready, rvalid, sck_o, sck_oe_n;
    wire                    sdi_o, sdi_oe_n, sdo_o, sdo_oe_n, done_flag, p_sck, p_sd;
    wire [1:0]              bresp, rresp;
    wire [31:0]             rdata;
    int                     num_errors = 0, compares = 0, n;
    // Resolved pin levels; data output line has a pull-up
    wire sck_w = !sck_oe_n ? sck_o : p_sck;
    wire sdo_w = !sdo_oe_n ? sdo_o : 1'b1;
    always #4 aclk = ~aclk;
    sst_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sck_i(sck_w), .sck_o(sck_o), .sck_oe_n(sck_oe_n), .sdi_i(p_sd), .sdi_o(sdi_o),
        .sdi_oe_n(sdi_oe_n), .sdo_i(sdo_w), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n),
        .done_flag(done_flag));
    sst_peer i_peer (.arm(p_arm), .clock_idle_polarity_bit(p_clock_idle_polarity_bit), .sample_phase_bit(p_sample_phase_bit), .lsb_first(p_lsb),
        .tx(p_tx), .sck_in(sck_w), .sd_in(sdo_w), .sck_out(p_sck), .sd_out(p_sd), .rx(p_rx));
    // Cycles between serial clock toggles
    always @(posedge aclk) begin
        run_len <= (sck_o != prev_sck) ? 32'h0 : run_len + 1;
        if (sck_o != prev_sck) last_gap <= run_len + 1;
        prev_sck <= sck_o;
    end
    function automatic logic [31:0] half_period(input logic [1:0] rt, input logic [7:0] rl);
        int d;
        d = (rt == `SST_RATE_CPU) ? 1 : (rt == `SST_RATE_DIV32) ? 32 :
            (rt == `SST_RATE_DIV16) ? 16 : 8;
        return 32'((256 - rl) * d);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("Errors %0d, compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // A wait past its bound counts as a mismatch
    task automatic guard(input int k);
        if (k > 20000) begin
            num_errors++;
            results();
        end
    endtask
    // Write: AW and W offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic aw, w, b;
        int k;
        {aw, w, b, k} = {3'b110, 32'h0};
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'b111};
        while (!b) begin
            @(negedge aclk);
            {aw, w, b, resp} = {aw & !awready, w & !wready, bvalid, bresp};
            @(posedge aclk);
            {awvalid, wvalid, bready} <= {aw, w, !b};
            guard(++k);
        end
    endtask
    task automatic rd(input logic [11:0] a);
        logic ar, v;
        int k;
        {ar, v, k} = {2'b10, 32'h0};
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        while (!v) begin
            @(negedge aclk);
            {ar, v, rv, resp} = {ar & !arready, rvalid, rdata, rresp};
            @(posedge aclk);
            {arvalid, rready} <= {ar, !v};
            guard(++k);
        end
    endtask
    initial begin
        n = $urandom(16);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, write-only reload, unmapped place
        rd(`SST_ADDR_MODE);
        check(rv, 32'h0);
        wr(`SST_ADDR_RELOAD, 8'h5a);
        rd(`SST_ADDR_RELOAD);
        check(rv, 32'h0);
        rd(12'h100);
        check(resp, `SST_RESP_SLVERR);
        wr(`SST_ADDR_PORT, 8'h07);
        repeat (2) @(negedge aclk);
        check({sck_oe_n, sdi_oe_n, sdo_oe_n}, 3'b000);
        wr(`SST_ADDR_PORT, 8'h00);
        wr(`SST_ADDR_MODE, 8'hc0);
        rd(`SST_ADDR_MODE);
        check(rv, 32'h80);
        check({sck_oe_n, sdi_oe_n, sdo_oe_n}, 3'b010);
        // Every rate in both roles, random order, phase and polarity
        for (int i = 0; i < 8; i++) begin
            {tx, p_tx} = (i == 0) ? 16'h0180 : 16'($urandom);
            rel = 8'hf8 + 8'($urandom % 5); // Half period >= 4 for pin sync
            cfg = {2'b10, 2'(i), 1'($urandom), 1'(i >> 2), 2'($urandom)};
            port = (i % 2) ? 8'h08 : 8'h00;
            wr(`SST_ADDR_PORT, port);
            wr(`SST_ADDR_RELOAD, rel);
            wr(`SST_ADDR_DATA, tx);
            wr(`SST_ADDR_MODE, cfg);
            @(posedge aclk);
            {p_clock_idle_polarity_bit, p_sample_phase_bit, p_lsb, p_arm} <= {cfg[1], cfg[0], cfg[3], 1'b0};
            @(posedge aclk);
            p_arm <= 1'b1;
            wr(`SST_ADDR_MODE, cfg | 8'h40);
            rd(`SST_ADDR_MODE);
            check(rv[7:6], 2'b11);
            if (cfg[2]) i_peer.burst();
            n = 0;
            while (done_flag !== 1'b1) begin
                @(negedge aclk);
                guard(++n);
            end
            repeat (2) @(negedge aclk);
            check(p_rx, tx);
            rd(`SST_ADDR_DATA);
            check(rv, {24'h0, p_tx});
            rd(`SST_ADDR_MODE);
            check(rv, {24'h0, cfg});
            if (!cfg[2]) check(last_gap, half_period(cfg[5:4], rel));
            check(sck_w, cfg[1]);
            check(sck_oe_n, cfg[2]);
            if (!port[3]) check(sdo_oe_n, 1'b0);
            check(done_flag, 1'b1);
            wr(`SST_ADDR_STATUS, 8'h01);
            @(negedge aclk);
            check(done_flag, 1'b0);
        end
        wr(`SST_ADDR_MODE, 8'h00);
        repeat (2) @(negedge aclk);
        check({sck_oe_n, sdo_oe_n}, 2'b11);
        results();
    end
endmodule
bind sst_top sst_properties i_props (.*);
`default_nettype wire
